// File: src/sli_pkg.sv
// constants for the second-level interrupt status and mask block
// assumes a byte-wide register index and 16-bit register data
//
// ============================================================
// package
// ============================================================
package sli_pkg;

    // ============================================================
    // register port widths
    // ============================================================
    localparam int unsigned ADDR_W = 8;  // register index width
    localparam int unsigned DATA_W = 16; // register data width

    // ============================================================
    // register indices
    // ============================================================
    // first-level status, holds the codec group bit
    localparam logic [7:0] ADDR_FIRST_LEVEL_STATUS    = 8'h19;
    // status two, read clears
    localparam logic [7:0] ADDR_IRQ_STATUS_TWO        = 8'h1A;
    // comparator status, read clears
    localparam logic [7:0] ADDR_COMPARATOR_IRQ_STATUS = 8'h1F;
    // status two mask, read/write
    localparam logic [7:0] ADDR_IRQ_STATUS_TWO_MASK   = 8'h22;
    // comparator mask, read/write
    localparam logic [7:0] ADDR_COMPARATOR_IRQ_MASK   = 8'h27;

    // ============================================================
    // field positions
    // ============================================================
    localparam int unsigned BIT_SINK_FAULT     = 13; // status two
    localparam int unsigned BIT_USB_SUPPLY_FEEDBACK         = 15; // comparator
    localparam int unsigned BIT_ADAPTOR_FB     = 14; // comparator
    localparam int unsigned BIT_BATTERY_FB     = 13; // comparator
    localparam int unsigned BIT_LEFT_JACK      = 11; // comparator
    localparam int unsigned BIT_RIGHT_JACK     = 10; // comparator
    localparam int unsigned BIT_MIC_SHORT      = 9;  // comparator
    localparam int unsigned BIT_MIC_PRESENCE   = 8;  // comparator
    localparam int unsigned BIT_FIRST_CODEC    = 7;  // first level

    // low bit of each comparator group, groups are contiguous
    localparam int unsigned SUPPLY_LSB = 13; // supply group 15:13
    localparam int unsigned CODEC_LSB  = 8;  // codec group 11:8
    localparam int unsigned SUPPLY_N   = 3;  // supply sources
    localparam int unsigned CODEC_N    = 4;  // codec sources

    // ============================================================
    // reset values
    // ============================================================
    localparam logic       RST_SINK_MASK   = 1'b0;   // unmasked
    localparam logic [2:0] RST_SUPPLY_MASK = 3'h0;   // unmasked
    localparam logic [3:0] RST_CODEC_MASK  = 4'h0;   // unmasked
    localparam logic [15:0] RST_RDATA      = 16'h0000;

endpackage

// File: src/sli_flag_cell.sv
// one second-level interrupt flag: synchroniser, edge detect, sticky
// assumes the source is asynchronous to clk and clear is a
// one-cycle pulse from the register read decode on clk
`timescale 1ns/100ps

// ============================================================
// flag cell
// ============================================================
module sli_flag_cell #(
    parameter bit BOTH_EDGES = 1'b1 // 1: both edges, 0: rising only
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic src_async,
    input  wire logic clear,
    output logic      flag
);

    logic meta_r;    // first stage, read only by sync_r
    logic sync_r;    // second stage, safe to use
    logic prev_r;    // last synchronised level
    logic [2:0] prime_r; // top bit high once prev_r is a real sample
    logic event_nxt; // edge seen this cycle
    logic flag_r;    // sticky flag

    // ============================================================
    // two-stage synchroniser
    // ============================================================
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= src_async;
            sync_r <= meta_r;
        end
    end

    // ============================================================
    // edge history
    // ============================================================
    // priming stops a source that is already high at reset from
    // being mistaken for a fresh edge; meta, sync and prev need
    // three edges to hold real samples, so priming waits three
    // edges too; a change before the first edge after release is
    // lost, which is the price of no false flag at power-up
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_r  <= 1'b0;
            prime_r <= 3'h0;
        end else begin
            prev_r  <= sync_r;
            prime_r <= {prime_r[1:0], 1'b1};
        end
    end

    // edge detect, rising only or any change
    always_comb begin
        if (BOTH_EDGES) begin
            event_nxt = prime_r[2] & (sync_r ^ prev_r);
        end else begin
            event_nxt = prime_r[2] & sync_r & ~prev_r;
        end
    end

    // ============================================================
    // sticky flag: an edge in the clearing cycle wins
    // ============================================================
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= event_nxt | (flag_r & ~clear);
        end
    end

    assign flag = flag_r;

endmodule // sli_flag_cell

// File: src/sli_irq_top.sv
// second-level interrupt status and mask for the current sink,
// external supply and codec groups, with the first-level codec bit
// assumes a simple register port on clk: one-cycle read and write
// strobes, index and data valid with the strobe
`timescale 1ns/100ps

// ============================================================
// top
// ============================================================
module sli_irq_top (
    input  wire logic        clk,
    input  wire logic        reset_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // asynchronous source conditions
    input  wire logic        sink_regulation_lost,
    input  wire logic        usb_supply_feedback,
    input  wire logic        adaptor_supply_feedback,
    input  wire logic        battery_supply_feedback,
    input  wire logic        left_jack_detect,
    input  wire logic        right_jack_detect,
    input  wire logic        mic_short_detect,
    input  wire logic        mic_presence_detect,
    // first-level group interrupts, active high levels
    output logic             sink_group_irq,
    output logic             supply_group_irq,
    output logic             codec_group_irq
);

    // ============================================================
    // helper
    // ============================================================
    // any flag pending whose mask bit is clear, used by each group
    // the sink group pads its single flag into the same four-bit
    // form, so all three groups share one definition of pending
    function automatic logic pending4(input logic [3:0] flags,
                                      input logic [3:0] masks);
        pending4 = |(flags & ~masks);
    endfunction

    // ============================================================
    // declarations
    // ============================================================
    logic        rd_first_level;   // read of first-level status
    logic        rd_status_two;    // read of status two
    logic        rd_comparator;    // read of comparator status
    logic        wr_status_two_m;  // write of status two mask
    logic        wr_comparator_m;  // write of comparator mask

    logic        sink_regulation_fault_flag; // status two bit 13
    logic [6:0]  comp_src;         // comparator sources, codec low
    logic [6:0]  comp_flag;        // comparator flags, codec low

    logic        usb_feedback_change_flag;
    logic        adaptor_feedback_change_flag;
    logic        battery_feedback_change_flag;
    logic        left_jack_detect_flag;
    logic        right_jack_detect_flag;
    logic        mic_short_detect_flag;
    logic        mic_presence_flag;

    logic        sink_regulation_fault_mask_r; // status two mask 13
    logic [2:0]  supply_mask_r;    // comparator mask 15:13
    logic [3:0]  codec_mask_r;     // comparator mask 11:8

    logic        sink_pend;        // unmasked sink flag
    logic        supply_pend;      // any unmasked supply flag
    logic        codec_pend;       // any unmasked codec flag
    logic        first_codec_r;    // first-level codec bit

    logic [15:0] status_two_word;  // read image, status two
    logic [15:0] comparator_word;  // read image, comparator
    logic [15:0] status_two_m_word; // read image, status two mask
    logic [15:0] comparator_m_word; // read image, comparator mask
    logic [15:0] first_level_word;  // read image, first level
    logic [15:0] rdata_nxt;        // next read data

    // ============================================================
    // register decode
    // ============================================================
    // strobes come from logic on clk, so they are used directly
    // writes to status indices decode to nothing and are ignored
    assign rd_first_level  = reg_rd &
        (reg_addr == sli_pkg::ADDR_FIRST_LEVEL_STATUS);
    assign rd_status_two   = reg_rd &
        (reg_addr == sli_pkg::ADDR_IRQ_STATUS_TWO);
    assign rd_comparator   = reg_rd &
        (reg_addr == sli_pkg::ADDR_COMPARATOR_IRQ_STATUS);
    assign wr_status_two_m = reg_wr &
        (reg_addr == sli_pkg::ADDR_IRQ_STATUS_TWO_MASK);
    assign wr_comparator_m = reg_wr &
        (reg_addr == sli_pkg::ADDR_COMPARATOR_IRQ_MASK);

    // ============================================================
    // current sink fault flag
    // ============================================================
    // the only source of the sink group, rising edge only
    sli_flag_cell #(
        .BOTH_EDGES (1'b0)
    ) u_sink_flag (
        .clk        (clk),
        .reset_n    (reset_n),
        .src_async  (sink_regulation_lost),
        .clear      (rd_status_two),
        .flag       (sink_regulation_fault_flag)
    );

    // ============================================================
    // comparator flags: supply and codec
    // ============================================================
    // source order follows bit order, bit 8 upward with 12 skipped
    assign comp_src = {usb_supply_feedback,
                       adaptor_supply_feedback,
                       battery_supply_feedback,
                       left_jack_detect,
                       right_jack_detect,
                       mic_short_detect,
                       mic_presence_detect};

    // every one of these latches on any change of its source
    for (genvar g = 0; g < 7; g++) begin : g_comp
        sli_flag_cell #(
            .BOTH_EDGES (1'b1)
        ) u_flag (
            .clk        (clk),
            .reset_n    (reset_n),
            .src_async  (comp_src[g]),
            .clear      (rd_comparator),
            .flag       (comp_flag[g])
        );
    end

    // named views of the comparator flags
    assign usb_feedback_change_flag     = comp_flag[6];
    assign adaptor_feedback_change_flag = comp_flag[5];
    assign battery_feedback_change_flag = comp_flag[4];
    assign left_jack_detect_flag        = comp_flag[3];
    assign right_jack_detect_flag       = comp_flag[2];
    assign mic_short_detect_flag        = comp_flag[1];
    assign mic_presence_flag            = comp_flag[0];

    // ============================================================
    // status two mask register
    // ============================================================
    // only bit 13 lives here; the other bits belong to other groups
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // unmasked out of reset
            sink_regulation_fault_mask_r <=
                sli_pkg::RST_SINK_MASK;
        end else if (wr_status_two_m) begin
            sink_regulation_fault_mask_r <=
                reg_wdata[sli_pkg::BIT_SINK_FAULT];
        end
    end

    // ============================================================
    // comparator mask register
    // ============================================================
    // supply bits 15:13 and codec bits 11:8, bit 12 is not stored
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            supply_mask_r <= sli_pkg::RST_SUPPLY_MASK;
            codec_mask_r  <= sli_pkg::RST_CODEC_MASK;
        end else if (wr_comparator_m) begin
            supply_mask_r <=
                reg_wdata[sli_pkg::SUPPLY_LSB +: sli_pkg::SUPPLY_N];
            codec_mask_r  <=
                reg_wdata[sli_pkg::CODEC_LSB +: sli_pkg::CODEC_N];
        end
    end

    // ============================================================
    // group pending terms
    // ============================================================
    // masks gate the group outputs and the first-level codec bit, never the flags themselves
    assign sink_pend   = pending4({3'h0, sink_regulation_fault_flag},
        {3'h0, sink_regulation_fault_mask_r});
    assign supply_pend = pending4({1'b0, comp_flag[6:4]},
        {1'b0, supply_mask_r});
    assign codec_pend  = pending4(comp_flag[3:0],
        codec_mask_r);

    // ============================================================
    // first-level codec bit
    // ============================================================
    // sticky copy of the codec group; a pending codec flag in the
    // clearing cycle keeps it set, so nothing slips past a read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            first_codec_r <= 1'b0;
        end else begin
            first_codec_r <= codec_pend |
                (first_codec_r & ~rd_first_level);
        end
    end

    // ============================================================
    // first-level outputs
    // ============================================================
    // combinational from flops, no extra cycle of latency
    // flags and masks are both flops, so these outputs cannot
    // glitch from a source edge; a mask write shows right after
    // the edge that takes it
    assign sink_group_irq   = sink_pend;
    assign supply_group_irq = supply_pend;
    assign codec_group_irq  = codec_pend;

    // ============================================================
    // read images
    // ============================================================
    // unused bits read as zero
    always_comb begin
        status_two_word   = 16'h0000;
        comparator_word   = 16'h0000;
        status_two_m_word = 16'h0000;
        comparator_m_word = 16'h0000;
        first_level_word  = 16'h0000;
        // masked flags remain visible here
        status_two_word[sli_pkg::BIT_SINK_FAULT] =
            sink_regulation_fault_flag;
        comparator_word[sli_pkg::BIT_USB_SUPPLY_FEEDBACK] =
            usb_feedback_change_flag;
        comparator_word[sli_pkg::BIT_ADAPTOR_FB] =
            adaptor_feedback_change_flag;
        comparator_word[sli_pkg::BIT_BATTERY_FB] =
            battery_feedback_change_flag;
        comparator_word[sli_pkg::BIT_LEFT_JACK] =
            left_jack_detect_flag;
        comparator_word[sli_pkg::BIT_RIGHT_JACK] =
            right_jack_detect_flag;
        comparator_word[sli_pkg::BIT_MIC_SHORT] =
            mic_short_detect_flag;
        comparator_word[sli_pkg::BIT_MIC_PRESENCE] =
            mic_presence_flag;
        status_two_m_word[sli_pkg::BIT_SINK_FAULT] =
            sink_regulation_fault_mask_r;
        comparator_m_word[sli_pkg::SUPPLY_LSB +: sli_pkg::SUPPLY_N] =
            supply_mask_r;
        comparator_m_word[sli_pkg::CODEC_LSB +: sli_pkg::CODEC_N] =
            codec_mask_r;
        first_level_word[sli_pkg::BIT_FIRST_CODEC] =
            first_codec_r;
    end

    // ============================================================
    // read mux
    // ============================================================
    // unmapped indices answer zero
    always_comb begin
        case (reg_addr)
            sli_pkg::ADDR_FIRST_LEVEL_STATUS: begin
                rdata_nxt = first_level_word;
            end
            sli_pkg::ADDR_IRQ_STATUS_TWO: begin
                rdata_nxt = status_two_word;
            end
            sli_pkg::ADDR_COMPARATOR_IRQ_STATUS: begin
                rdata_nxt = comparator_word;
            end
            sli_pkg::ADDR_IRQ_STATUS_TWO_MASK: begin
                rdata_nxt = status_two_m_word;
            end
            sli_pkg::ADDR_COMPARATOR_IRQ_MASK: begin
                rdata_nxt = comparator_m_word;
            end
            default: begin
                rdata_nxt = 16'h0000;
            end
        endcase
    end

    // ============================================================
    // read data register
    // ============================================================
    // captures the value before the clear, so a read returns the
    // flags it is clearing; held until the next read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= sli_pkg::RST_RDATA;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end
    end

endmodule // sli_irq_top

// File: verif/sli_irq_props.sv
// assertion checker for the second-level interrupt block top ports
// assumes the bind below attaches it to every sli_irq_top instance
`timescale 1ns/100ps

// ============================================================
// checker
// ============================================================
module sli_irq_props (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        sink_regulation_lost,
    input wire logic        sink_group_irq,
    input wire logic        supply_group_irq,
    input wire logic        codec_group_irq
);
    logic       sm_r; // mirrored sink mask
    logic [2:0] pm_r; // mirrored supply masks
    logic [3:0] cm_r; // mirrored codec masks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // mirror mask writes, only documented bits are kept
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sm_r <= 1'b0;
            pm_r <= 3'h0;
            cm_r <= 4'h0;
        end else if (reg_wr && reg_addr == 8'h22) begin
            sm_r <= reg_wdata[13];
        end else if (reg_wr && reg_addr == 8'h27) begin
            pm_r <= reg_wdata[15:13];
            cm_r <= reg_wdata[11:8];
        end
    end

    // rising source, unmasked, no register traffic for three cycles
    sequence s_sink_rise;
        $rose(sink_regulation_lost) && !sm_r ##1 (!reg_rd && !reg_wr) [*3];
    endsequence
    // source quiet long enough that no event is still in flight
    sequence s_quiet_clear;
        $stable(sink_regulation_lost) [*4] ##0
            (reg_rd && reg_addr == 8'h1A);
    endsequence

    property p_sink_rise;
        s_sink_rise |-> ##[0:1] sink_group_irq;
    endproperty
    a_sink_rise: assert property (p_sink_rise)
        else $error("sink fault did not raise its interrupt");
    property p_rdclr_sink;
        s_quiet_clear |=> !sink_group_irq;
    endproperty
    a_rdclr_sink: assert property (p_rdclr_sink)
        else $error("status read left sink flag set");
    property p_sticky_sink;
        sink_group_irq && !reg_wr && !(reg_rd && reg_addr == 8'h1A)
            |=> sink_group_irq;
    endproperty
    a_sticky_sink: assert property (p_sticky_sink)
        else $error("sink flag dropped without a read");
    property p_sink_mask;
        sm_r |-> !sink_group_irq;
    endproperty
    a_sink_mask: assert property (p_sink_mask)
        else $error("masked sink flag reached its interrupt");
    property p_supply_mask;
        (&pm_r) |-> !supply_group_irq;
    endproperty
    a_supply_mask: assert property (p_supply_mask)
        else $error("masked supply flags reached interrupt");
    property p_codec_mask;
        (&cm_r) |-> !codec_group_irq;
    endproperty
    a_codec_mask: assert property (p_codec_mask)
        else $error("masked codec flags reached interrupt");
    property p_codec_bit;
        codec_group_irq [*2] ##0 (reg_rd && reg_addr == 8'h19)
            |=> reg_rdata == 16'h0080;
    endproperty
    a_codec_bit: assert property (p_codec_bit)
        else $error("first-level codec bit not read back");
    property p_unmapped;
        reg_rd && !(reg_addr inside {8'h19, 8'h1A, 8'h1F, 8'h22, 8'h27})
            |=> reg_rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned data");
endmodule // sli_irq_props

bind sli_irq_top sli_irq_props i_sli_irq_props (.clk, .reset_n,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .sink_regulation_lost, .sink_group_irq, .supply_group_irq,
    .codec_group_irq);

// File: verif/test_sli_irq_top.sv
// self-checking bench for the second-level interrupt block
// assumes src/ files and the checker are compiled first
`timescale 1ns/100ps

module test_sli_irq_top;
    // ============================================================
    // signals
    // ============================================================
    logic        clk;       // 10 MHz clock
    logic        reset_n;   // async reset, active low
    logic [7:0]  reg_addr;  // register index
    logic        reg_wr;    // write strobe
    logic        reg_rd;    // read strobe
    logic [15:0] reg_wdata; // write data
    logic [15:0] reg_rdata; // read data
    logic        sink_src;  // sink cannot regulate
    logic [6:0]  cmp_src;   // usb, adaptor, battery, jacks, mics
    logic [2:0]  irqs;      // sink, supply, codec levels
    logic [15:0] got;       // last read word
    int          errors;    // mismatches
    int          tests_run; // comparisons
    int          bits [7] = '{15, 14, 13, 11, 10, 9, 8}; // flag bits

    sli_irq_top i_sli_irq_top (.clk(clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sink_regulation_lost(sink_src),
        .usb_supply_feedback(cmp_src[6]),
        .adaptor_supply_feedback(cmp_src[5]),
        .battery_supply_feedback(cmp_src[4]),
        .left_jack_detect(cmp_src[3]), .right_jack_detect(cmp_src[2]),
        .mic_short_detect(cmp_src[1]), .mic_presence_detect(cmp_src[0]),
        .sink_group_irq(irqs[2]), .supply_group_irq(irqs[1]),
        .codec_group_irq(irqs[0]));

    // ============================================================
    // clock and tasks, all entered just after a rising edge
    // ============================================================
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1 reg_wr = 1'b0;
        // one idle edge so a following write never re-raises reg_wr
        // in the time step that lowered it
        @(posedge clk);
        #1;
    endtask
    // data is held after the taking edge, so sample one edge later
    task automatic rd(input logic [7:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        @(posedge clk);
        #1 got = reg_rdata;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        rd(a);
        chk(got, e);
    endtask
    task automatic irqchk(input logic [2:0] e);
        chk({13'h0000, irqs}, {13'h0000, e});
    endtask
    // four edges cover the two-stage sync plus the flag edge
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop;
        if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ============================================================
    // main sequence
    // ============================================================
    initial begin
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
        sink_src = 1'b0;
        cmp_src = 7'h00;
        errors = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        #1 reset_n = 1'b1;
        idle(4);
        rdchk(8'h22, 16'h0000);
        rdchk(8'h27, 16'h0000);
        rdchk(8'h20, 16'h0000);
        wr(8'h1A, 16'hFFFF);
        rdchk(8'h1A, 16'h0000);
        // sink flag: rising edge latches, falling does not
        sink_src = 1'b1;
        idle(4);
        irqchk(3'b100);
        rdchk(8'h1A, 16'h2000);
        irqchk(3'b000);
        sink_src = 1'b0;
        idle(4);
        rdchk(8'h1A, 16'h0000);
        // masked sink flag latches but stays off the interrupt
        wr(8'h22, 16'hFFFF);
        rdchk(8'h22, 16'h2000);
        sink_src = 1'b1;
        idle(4);
        irqchk(3'b000);
        wr(8'h22, 16'h0000);
        irqchk(3'b100);
        rdchk(8'h1A, 16'h2000);
        // each comparator flag on both edges, one at a time
        for (int i = 0; i < 7; i++) begin
            for (int k = 0; k < 2; k++) begin
                cmp_src[6-i] = ~cmp_src[6-i];
                idle(4);
                irqchk(i < 3 ? 3'b010 : 3'b001);
                rdchk(8'h1F, 16'h0001 << bits[i]);
            end
        end
        // all masked, then one group at a time unmasked
        wr(8'h27, 16'hFFFF);
        rdchk(8'h27, 16'hEF00);
        cmp_src = 7'h7F;
        idle(4);
        irqchk(3'b000);
        wr(8'h27, 16'hE000);
        irqchk(3'b001);
        wr(8'h27, 16'h0F00);
        irqchk(3'b010);
        rdchk(8'h1F, 16'hEF00);
        // first-level codec bit, cleared by its read once the codec group is low
        wr(8'h27, 16'h0000);
        cmp_src[3] = 1'b0;
        idle(4);
        rdchk(8'h19, 16'h0080);
        rdchk(8'h1F, 16'h0800);
        rd(8'h19);
        rdchk(8'h19, 16'h0000);
        // mid-run reset with sources high: masks return to zero and
        // a source already high at release sets no flag
        wr(8'h22, 16'hFFFF);
        wr(8'h27, 16'hFFFF);
        reset_n = 1'b0;
        idle(2);
        reset_n = 1'b1;
        idle(4);
        rdchk(8'h22, 16'h0000);
        rdchk(8'h27, 16'h0000);
        rdchk(8'h1A, 16'h0000);
        rdchk(8'h1F, 16'h0000);
        irqchk(3'b000);
        report_and_stop();
    end
endmodule // test_sli_irq_top
